// [spv_pkg.sv]
package spv_pkg;

  // Command codes, six bits, shifted in least significant bit first.
  localparam logic [5:0] CMD_LOAD_CFG = 6'h00;
  localparam logic [5:0] CMD_LOAD_DATA = 6'h02;
  localparam logic [5:0] CMD_READ_DATA = 6'h04;
  localparam logic [5:0] CMD_INC_ADDR = 6'h06;
  localparam logic [5:0] CMD_BEGIN_PROG = 6'h08;
  localparam logic [5:0] CMD_END_PROG = 6'h0E;

  // Frame layout.
  localparam int CMD_BITS = 6;
  localparam int WORD_BITS = 14;
  localparam logic [3:0] CMD_LAST_BIT = 4'h5;
  localparam logic [3:0] FRAME_LAST_BIT = 4'hE;
  localparam logic [3:0] FRAME_STOP = 4'hF;

  // Address map in program/verify mode.
  localparam logic [13:0] CFG_BASE = 14'h2000;
  localparam int CFG_SPACE_BIT = 13;
  localparam int CFG_IMPL_BITS = 8;
  localparam logic [7:0] CFG_WORD_INDEX = 8'h07;

  // Configuration word fields and blank value.
  localparam logic [13:0] CFG_RESET = 14'h3FFF;
  localparam int OSC_LSB = 0;
  localparam int WDT_BIT = 2;
  localparam int PWRT_BIT = 3;
  localparam int CP_LSB = 4;

  // Code protect codes.
  localparam logic [1:0] CP_ALL = 2'h0;
  localparam logic [1:0] CP_UPPER_3Q = 2'h1;
  localparam logic [1:0] CP_UPPER_HALF = 2'h2;

  // Buffer of loaded words awaiting a programming pulse.
  localparam int BUF_DEPTH = 16;

  typedef enum logic [1:0] {SPV_CMD, SPV_LOAD, SPV_READ} spv_state_t;

endpackage : spv_pkg

// [spv_port.sv]
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////

module spv_fifo #(
  parameter int WIDTH = 28,
  parameter int DEPTH = 16
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW:0] wr;
    logic [AW:0] rd;
  } spv_fifo_t;

  spv_fifo_t q;
  spv_fifo_t d;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push;
  logic pop;

  assign in_ready = (q.wr - q.rd) != DEPTH[AW:0];
  assign out_valid = q.wr != q.rd;
  assign out_data = mem[q.rd[AW-1:0]];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb
  begin
    d = q;
    if (flush)
    begin
      d.wr = '0;
      d.rd = '0;
    end
    else
    begin
      if (push)
        d.wr = q.wr + 1'b1;
      if (pop)
        d.rd = q.rd + 1'b1;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      q <= '0;
    else
      q <= d;
  end

  always_ff @(posedge core_clk)
  begin
    if (push && !flush)
      mem[q.wr[AW-1:0]] <= in_data;
  end

endmodule : spv_fifo

////////////////////////////////////////////////////////////////////////////////

module spv_port
  import spv_pkg::*;
#(
  parameter int USER_AW = 11
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic serial_prog_clock_pin,
  input wire logic serial_prog_data_pin_in,
  output logic serial_prog_data_pin_out,
  output logic serial_prog_data_pin_oe,
  input wire logic clear_high_voltage_pin,
  output logic prog_mode_active,
  output logic other_logic_reset,
  output logic cpu_clock_enable,
  output logic programming_active,
  output logic load_overflow,
  output logic [1:0] oscillator_select,
  output logic watchdog_enable_bit,
  output logic powerup_delay_enable_n,
  output logic protect_select_hi,
  output logic protect_select_lo
);

  localparam int ENTRY_W = 2 * WORD_BITS;

  typedef struct packed {
    logic [2:0] clk_s;
    logic [2:0] dat_s;
    logic [2:0] hv_s;
    logic clk_lv;
    logic mode;
    spv_state_t st;
    logic [3:0] cnt;
    logic [5:0] cmd_sr;
    logic [13:0] pc;
    logic [13:0] sh;
    logic prog;
    logic wrote;
    logic dout;
    logic oe;
    logic ovf;
    logic [13:0] cfg;
  } spv_port_t;

  spv_port_t q;
  spv_port_t d;
  logic [13:0] umem [2**USER_AW];
  logic [13:0] cmem [2**CFG_IMPL_BITS];

  logic clk_stable;
  logic rise;
  logic fall;
  logic din;
  logic hv_stable;
  logic push;
  logic buf_ready;
  logic [ENTRY_W-1:0] head;
  logic head_valid;
  logic pop;
  logic wr_user;
  logic wr_cfg;
  logic [13:0] head_addr;
  logic [13:0] head_word;

  // Protection decode; a code that a variant does not support leaves it open.
  function automatic logic prot_f(input logic [13:0] a, input logic [1:0] cp);
    logic p;
    p = 1'b0;
    if (!a[CFG_SPACE_BIT])
    begin
      case (cp)
        CP_ALL: p = 1'b1;
        CP_UPPER_3Q:
        begin
          if (USER_AW >= 11)
            p = a[10] || a[9];
          else if (USER_AW == 10)
            p = a[9];
        end
        CP_UPPER_HALF: p = (USER_AW >= 11) && a[10];
        default: p = 1'b0;
      endcase
    end
    return p;
  endfunction : prot_f

  // Word seen by a read at the given address.
  function automatic logic [13:0] rd_f(input logic [13:0] a);
    logic [13:0] w;
    w = '0;
    if (a[CFG_SPACE_BIT])
    begin
      if (a[CFG_IMPL_BITS-1:0] == CFG_WORD_INDEX)
        w = q.cfg;
      else
        w = cmem[a[CFG_IMPL_BITS-1:0]];
    end
    else if (!prot_f(a, q.cfg[CP_LSB +: 2]))
      w = umem[a[USER_AW-1:0]];
    return w;
  endfunction : rd_f

  assign clk_stable = q.clk_s[1] == q.clk_s[2];
  assign rise = clk_stable && q.clk_s[2] && !q.clk_lv;
  assign fall = clk_stable && !q.clk_s[2] && q.clk_lv;
  assign din = q.dat_s[2];
  assign hv_stable = q.hv_s[1] == q.hv_s[2];
  assign head_addr = head[ENTRY_W-1 -: WORD_BITS];
  assign head_word = head[WORD_BITS-1:0];
  assign pop = head_valid && q.prog && !q.wrote;
  assign wr_cfg = pop && head_addr[CFG_SPACE_BIT];
  assign wr_user = pop && !head_addr[CFG_SPACE_BIT]
    && !prot_f(head_addr, q.cfg[CP_LSB +: 2]);

  ////////////////////////////////////////////////////////////////////////////

  always_comb
  begin
    d = q;
    push = 1'b0;
    d.clk_s = {q.clk_s[1:0], serial_prog_clock_pin};
    d.dat_s = {q.dat_s[1:0], serial_prog_data_pin_in};
    d.hv_s = {q.hv_s[1:0], clear_high_voltage_pin};
    if (clk_stable)
      d.clk_lv = q.clk_s[2];
    if (hv_stable)
      d.mode = q.hv_s[2];
    if (pop)
      d.wrote = 1'b1;
    if (!q.mode)
    begin
      // Outside the mode all but the pin samplers, the mode flag, the shift word and the nonvolatile words starts over.
      d.st = SPV_CMD;
      d.cnt = '0;
      d.cmd_sr = '0;
      d.pc = '0;
      d.prog = 1'b0;
      d.wrote = 1'b0;
      d.oe = 1'b0;
      d.dout = 1'b0;
      d.ovf = 1'b0;
    end
    else
    begin
      case (q.st)
        SPV_CMD:
        begin
          if (fall)
          begin
            d.cmd_sr = {din, q.cmd_sr[5:1]};
            d.cnt = q.cnt + 4'h1;
            if (q.cnt == CMD_LAST_BIT)
            begin
              d.cnt = '0;
              case ({din, q.cmd_sr[5:1]})
                CMD_LOAD_CFG:
                begin
                  d.pc = CFG_BASE;
                  d.st = SPV_LOAD;
                end
                CMD_LOAD_DATA: d.st = SPV_LOAD;
                CMD_READ_DATA:
                begin
                  d.sh = rd_f(q.pc);
                  d.st = SPV_READ;
                end
                CMD_INC_ADDR:
                  d.pc = {q.pc[CFG_SPACE_BIT],
                    q.pc[12:0] + 13'h0001};
                CMD_BEGIN_PROG:
                begin
                  d.prog = 1'b1;
                  d.wrote = 1'b0;
                end
                CMD_END_PROG: d.prog = 1'b0;
                default: d.cmd_sr = '0;
              endcase
            end
          end
        end
        SPV_LOAD:
        begin
          if (fall)
          begin
            d.cnt = q.cnt + 4'h1;
            if (q.cnt >= 4'h1 && q.cnt <= FRAME_LAST_BIT)
              d.sh = {din, q.sh[13:1]};
            if (q.cnt == FRAME_STOP)
            begin
              push = 1'b1;
              if (!buf_ready)
                d.ovf = 1'b1;
              d.cnt = '0;
              d.st = SPV_CMD;
            end
          end
        end
        SPV_READ:
        begin
          if (rise && q.cnt >= 4'h1 && q.cnt <= FRAME_LAST_BIT)
          begin
            d.oe = 1'b1;
            d.dout = q.sh[0];
            d.sh = {1'b0, q.sh[13:1]};
          end
          else if (rise && q.cnt == FRAME_STOP)
          begin
            d.oe = 1'b0;
            d.dout = 1'b0;
          end
          if (fall)
          begin
            d.cnt = q.cnt + 4'h1;
            if (q.cnt == FRAME_STOP)
            begin
              d.cnt = '0;
              d.st = SPV_CMD;
            end
          end
        end
        default: d.st = SPV_CMD;
      endcase
    end
    if (wr_cfg && head_addr[CFG_IMPL_BITS-1:0] == CFG_WORD_INDEX)
      d.cfg = q.cfg & head_word;
  end

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      q <= '0;
      q.st <= SPV_CMD;
      q.cfg <= CFG_RESET;
    end
    else
      q <= d;
  end

  // One-time-programmable cells: programming only clears bits.
  always_ff @(posedge core_clk)
  begin
    if (wr_user)
      umem[head_addr[USER_AW-1:0]] <= umem[head_addr[USER_AW-1:0]] & head_word;
    if (wr_cfg)
      cmem[head_addr[CFG_IMPL_BITS-1:0]] <=
        cmem[head_addr[CFG_IMPL_BITS-1:0]] & head_word;
  end

  spv_fifo #(
    .WIDTH(ENTRY_W),
    .DEPTH(BUF_DEPTH)
  ) u_buf (
    .core_clk(core_clk),
    .nrst(nrst),
    .flush(!q.mode),
    .in_valid(push),
    .in_ready(buf_ready),
    .in_data({q.pc, q.sh}),
    .out_valid(head_valid),
    .out_ready(pop),
    .out_data(head)
  );

  assign serial_prog_data_pin_out = q.dout;
  assign serial_prog_data_pin_oe = q.oe;
  assign prog_mode_active = q.mode;
  assign other_logic_reset = q.mode;
  assign cpu_clock_enable = 1'b0 ^ q.clk_lv & 1'b0;
  assign programming_active = q.prog;
  assign load_overflow = q.ovf;
  assign oscillator_select = q.cfg[OSC_LSB +: 2];
  assign watchdog_enable_bit = q.cfg[WDT_BIT];
  assign powerup_delay_enable_n = q.cfg[PWRT_BIT];
  assign protect_select_hi = q.cfg[CP_LSB + 1];
  assign protect_select_lo = q.cfg[CP_LSB];

endmodule : spv_port

// [spv_programmer.sv]
`timescale 1ns/1ps

module spv_programmer
  import spv_pkg::*;
(
  output logic sclk,
  output logic clr,
  output logic sdo,
  output logic sdo_en,
  input wire logic sdi
);
  logic b;

  initial
  begin
    sclk = 1'b0;
    clr = 1'b0;
    sdo = 1'b0;
    sdo_en = 1'b1;
  end

  task automatic enter;
    sdo = 1'b0;
    clr = 1'b1;
    #2000;
  endtask : enter

  task automatic leave;
    clr = 1'b0;
    #2000;
  endtask : leave

  // A released data line toggles each cycle so stale values never match.
  task automatic tick(input logic v);
    sdo = sdo_en ? v : ~sdo;
    sclk = 1'b1;
    #62.5;
    b = sdi;
    sclk = 1'b0;
    #62.5;
  endtask : tick

  task automatic cmd(input logic [5:0] c);
    #1000.3;
    for (int i = 0; i < CMD_BITS; i++)
      tick(c[i]);
  endtask : cmd

  task automatic load(input logic [13:0] w);
    logic [15:0] f;
    f = {1'b0, w, 1'b0};
    #1000.3;
    for (int i = 0; i < 16; i++)
      tick(f[i]);
  endtask : load

  task automatic read(output logic [13:0] w);
    #1000.3;
    sdo_en = 1'b0;
    for (int i = 0; i < 16; i++)
    begin
      tick(1'b0);
      if (i > 0 && i < 15)
        w[i-1] = b;
    end
    sdo_en = 1'b1;
  endtask : read
endmodule : spv_programmer

// [spv_port_properties.sv]
`timescale 1ns/1ps

module spv_port_props (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic serial_prog_clock_pin,
  input wire logic serial_prog_data_pin_out,
  input wire logic serial_prog_data_pin_oe,
  input wire logic clear_high_voltage_pin,
  input wire logic prog_mode_active,
  input wire logic other_logic_reset,
  input wire logic cpu_clock_enable,
  input wire logic programming_active,
  input wire logic [1:0] oscillator_select,
  input wire logic watchdog_enable_bit,
  input wire logic powerup_delay_enable_n,
  input wire logic protect_select_hi,
  input wire logic protect_select_lo
);
  wire logic [5:0] cfg = {oscillator_select, watchdog_enable_bit,
    powerup_delay_enable_n, protect_select_hi, protect_select_lo};
  wire logic sck = serial_prog_clock_pin;
  wire logic oe = serial_prog_data_pin_oe;

  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);

  a_cpu_clock_off: assert property (!cpu_clock_enable)
    else $error("cpu clock enabled");
  a_reset_with_mode: assert property (other_logic_reset == prog_mode_active)
    else $error("reset not tied to mode");
  a_mode_entry: assert property ($rose(clear_high_voltage_pin)
    |-> ##[2:6] prog_mode_active) else $error("mode not entered");
  a_mode_exit: assert property ($fell(clear_high_voltage_pin)
    |-> ##[2:6] !prog_mode_active && !oe) else $error("mode not left");
  a_drive_in_mode: assert property (oe |-> prog_mode_active)
    else $error("pin driven outside mode");
  a_drive_on_rise: assert property ($rose(oe) |-> sck)
    else $error("drive began off a rising edge");
  a_drive_holds: assert property ($rose(oe) |-> oe [*8])
    else $error("drive dropped early");
  a_bit_on_rise: assert property (oe &&
    $changed(serial_prog_data_pin_out) |-> sck)
    else $error("data bit changed off a rising edge");
  a_release_on_rise: assert property ($fell(oe) && prog_mode_active
    |-> sck) else $error("release off a rising edge");
  a_cfg_by_pulse: assert property ($changed(cfg) |-> programming_active)
    else $error("config changed outside a pulse");
  a_cfg_bits_otp: assert property ((~$past(cfg) & cfg) == 6'h00)
    else $error("programmed config bit returned to one");
endmodule : spv_port_props

bind spv_port spv_port_props spv_port_props_inst (.core_clk, .nrst,
  .serial_prog_clock_pin, .serial_prog_data_pin_out,
  .serial_prog_data_pin_oe, .clear_high_voltage_pin, .prog_mode_active,
  .other_logic_reset, .cpu_clock_enable, .programming_active,
  .oscillator_select, .watchdog_enable_bit, .powerup_delay_enable_n,
  .protect_select_hi, .protect_select_lo);

// [testbench.sv]
`timescale 1ns/1ps

`define CHK(a, e, m) begin n_checks++; if ((a) !== (e)) begin \
  fail_count++; $display("wrong value at %0t: %s", $time, m); end end

module testbench;
  import spv_pkg::*;

  logic core_clk, nrst, sclk, clr, sdo, sdo_en, dout, doe;
  logic mode, olr, pact, ovf, wdt, pwrtn, cph, cpl, cpu_en;
  logic [1:0] osc;
  logic [13:0] rd;
  int fail_count = 0;
  int n_checks = 0;
  wire logic dwire = doe ? dout : sdo;
  wire logic [5:0] cfg = {osc, wdt, pwrtn, cph, cpl};

  spv_programmer p (.sclk(sclk), .clr(clr), .sdo(sdo),
    .sdo_en(sdo_en), .sdi(dwire));

  spv_port spv_port_inst (.core_clk(core_clk), .nrst(nrst),
    .serial_prog_clock_pin(sclk), .serial_prog_data_pin_in(dwire),
    .serial_prog_data_pin_out(dout), .serial_prog_data_pin_oe(doe),
    .clear_high_voltage_pin(clr), .prog_mode_active(mode),
    .other_logic_reset(olr), .cpu_clock_enable(cpu_en),
    .programming_active(pact),
    .load_overflow(ovf), .oscillator_select(osc), .watchdog_enable_bit(wdt),
    .powerup_delay_enable_n(pwrtn), .protect_select_hi(cph),
    .protect_select_lo(cpl));

  function automatic logic [5:0] fexp(input logic [13:0] w);
    return {w[1:0], w[2], w[3], w[5], w[4]};
  endfunction : fexp

  task automatic results;
    if (fail_count == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : results

  // Pulses are shorter than the recommended length to keep the run short.
  task automatic pulse;
    p.cmd(CMD_BEGIN_PROG);
    #5000;
    `CHK(pact, 1'b1, "not programming")
    #5000;
    p.cmd(CMD_END_PROG);
    #200;
    `CHK(pact, 1'b0, "still programming")
  endtask : pulse

  task automatic t_user;
    `CHK(cfg, 6'h3F, "config not blank")
    p.enter;
    `CHK(olr, 1'b1, "logic not held")
    `CHK(cpu_en, 1'b0, "cpu clock running")
    p.cmd(CMD_LOAD_DATA);
    p.load(14'h0000);
    pulse;
    p.cmd(CMD_READ_DATA);
    p.read(rd);
    `CHK(rd, 14'h0000, "user word")
  endtask : t_user

  task automatic t_cfg;
    logic [13:0] w[3] = '{14'h3FF1, 14'h2AE1, 14'h00C1};
    p.cmd(CMD_LOAD_CFG);
    p.load(14'h3FFF);
    pulse;
    repeat (7) p.cmd(CMD_INC_ADDR);
    foreach (w[i])
    begin
      p.cmd(CMD_LOAD_DATA);
      p.load(w[i]);
      pulse;
      `CHK(cfg, fexp(w[i]), "config fields")
    end
    p.cmd(6'h01);
    p.cmd(6'h3F);
    p.cmd(CMD_READ_DATA);
    p.read(rd);
    `CHK(rd, 14'h00C1, "config word")
  endtask : t_cfg

  task automatic t_exit;
    p.leave;
    `CHK(mode, 1'b0, "mode kept")
    p.enter;
    p.cmd(CMD_INC_ADDR);
    p.cmd(CMD_READ_DATA);
    p.read(rd);
    `CHK(rd, 14'h0000, "protected word")
  endtask : t_exit

  task automatic t_fill;
    repeat (17)
    begin
      p.cmd(CMD_LOAD_DATA);
      p.load(14'h1555);
    end
    `CHK(ovf, 1'b1, "no overflow")
    p.leave;
    `CHK(ovf, 1'b0, "overflow kept")
  endtask : t_fill

  initial
  begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  initial
  begin
    #300000;
    fail_count++;
    results;
  end

  initial
  begin
    nrst = 1'b0;
    repeat (8) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    t_user;
    t_cfg;
    t_exit;
    t_fill;
    results;
  end
endmodule : testbench
